// ==== pll_reset_init_sequencer.sv ====
// Control map with indirect page window and PLL state-machine reset controls
`timescale 1ns/1ps
`include "pll_seq_params.svh"

module pll_reset_init_sequencer #(
	parameter int READY_CYCLES = `BUS_READY_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic device_enable_pin,
	input wire pll_seq_pkg::bus_req_t bus_req,
	input wire logic freq_change_det,
	input wire logic in_blanking,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic bus_ready,
	output pll_seq_pkg::pll_ctrl_t pll_ctrl,
	output logic link_pll_freq_reset,
	output logic video_enable
);

	//--------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------
	logic ready;
	logic dev_rst;
	logic wr_ok;
	logic rd_ok;
	logic [7:0] page_sel_ff;
	logic [7:0] page_ofs_ff;
	logic [7:0] freq_ctl_ff;
	logic [7:0] bus_filter_ff;
	logic [7:0] video_ctl_ff;
	logic [7:0] hdmi_pll_sm_control_ff;
	logic [7:0] link_pll_sm_control_ff;
	logic [7:0] rdata_ff;
	logic rvalid_ff;
	logic ready_ff;
	logic link_freq_rst_ff;
	logic video_en_ff;
	logic [7:0] nxt_rdata;

	// Keep only the documented control bit; reserved bits read zero
	function automatic logic [7:0] sm_field(input logic [7:0] d);
		sm_field = 8'h00;
		sm_field[`PLL_SM_RESET_BIT] = d[`PLL_SM_RESET_BIT];
	endfunction

	// True when the window points at a given page's control register
	function automatic logic win_hit(input logic [7:0] pg, input logic [7:0] ofs,
		input logic [7:0] want);
		win_hit = (pg == want) && (ofs == `PAGE_PLL_SM_OFS);
	endfunction

	//--------------------------------------------------------------
	// Enable pin acts as the device reset
	//--------------------------------------------------------------
	// Enable low clears the whole map, the same as a hard reset
	assign dev_rst = srst || !device_enable_pin;

	bus_ready_timer #(
		.READY_CYCLES(READY_CYCLES)
	) u_timer (
		.clk(clk),
		.srst(srst),
		.device_enable_pin(device_enable_pin),
		.ready(ready)
	);

	// Accesses before the bus is ready are dropped
	// A read that comes with a write in the same cycle loses
	assign wr_ok = bus_req.wr && ready;
	assign rd_ok = bus_req.rd && ready && !bus_req.wr;

	//--------------------------------------------------------------
	// Main control map
	//--------------------------------------------------------------
	// Window pointer registers
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			page_sel_ff <= `MAIN_REG_RST;
			page_ofs_ff <= `MAIN_REG_RST;
		end else if (wr_ok) begin
			if (bus_req.addr == `REG_PAGE_SEL) begin
				page_sel_ff <= bus_req.wdata;
			end
			if (bus_req.addr == `REG_PAGE_OFS) begin
				page_ofs_ff <= bus_req.wdata;
			end
		end
	end

	// Plain configuration registers used by sequence A
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			freq_ctl_ff <= `MAIN_REG_RST;
			bus_filter_ff <= `MAIN_REG_RST;
			video_ctl_ff <= `MAIN_REG_RST;
		end else if (wr_ok) begin
			if (bus_req.addr == `REG_FREQ_CTL) begin
				freq_ctl_ff <= bus_req.wdata;
			end
			if (bus_req.addr == `REG_BUS_FILTER) begin
				bus_filter_ff <= bus_req.wdata;
			end
			if (bus_req.addr == `REG_VIDEO_CTL) begin
				video_ctl_ff <= bus_req.wdata;
			end
		end
	end

	//--------------------------------------------------------------
	// Paged registers, only through the data window
	//--------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			hdmi_pll_sm_control_ff <= `PLL_SM_CONTROL_RST;
			link_pll_sm_control_ff <= `PLL_SM_CONTROL_RST;
		end else if (wr_ok && bus_req.addr == `REG_PAGE_DATA) begin
			if (win_hit(page_sel_ff, page_ofs_ff, `PAGE_HDMI)) begin
				hdmi_pll_sm_control_ff <= sm_field(bus_req.wdata);
			end
			if (win_hit(page_sel_ff, page_ofs_ff, `PAGE_LINK)) begin
				link_pll_sm_control_ff <= sm_field(bus_req.wdata);
			end
		end
	end

	// Read mux; window data returns the selected paged register
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (bus_req.addr)
			`REG_PAGE_SEL: nxt_rdata = page_sel_ff;
			`REG_PAGE_OFS: nxt_rdata = page_ofs_ff;
			`REG_PAGE_DATA: begin
				if (win_hit(page_sel_ff, page_ofs_ff, `PAGE_HDMI)) begin
					nxt_rdata = hdmi_pll_sm_control_ff;
				end else if (win_hit(page_sel_ff, page_ofs_ff, `PAGE_LINK)) begin
					nxt_rdata = link_pll_sm_control_ff;
				end
			end
			`REG_FREQ_CTL: nxt_rdata = freq_ctl_ff;
			`REG_BUS_FILTER: nxt_rdata = bus_filter_ff;
			`REG_VIDEO_CTL: nxt_rdata = video_ctl_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	// Read answer strobe, one cycle after the request
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= rd_ok;
		end
	end

	// Read data held until the next accepted read
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			rdata_ff <= 8'h00;
		end else if (rd_ok) begin
			rdata_ff <= nxt_rdata;
		end
	end

	//--------------------------------------------------------------
	// Effects on the PLL and video paths
	//--------------------------------------------------------------
	// Frequency-change reset only when the enable bit is set
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			link_freq_rst_ff <= 1'b0;
		end else begin
			link_freq_rst_ff <= freq_change_det && freq_ctl_ff[`FREQ_LINK_RESET_BIT];
		end
	end

	// Video held off in blanking when the blocking bit is set
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			video_en_ff <= 1'b0;
		end else begin
			video_en_ff <= !(in_blanking && video_ctl_ff[`VIDEO_NO_BLANK_BIT]);
		end
	end

	// Bus-open flag registered so the output comes from a flop
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= ready;
		end
	end

	assign rdata = rdata_ff;
	assign rvalid = rvalid_ff;
	assign bus_ready = ready_ff;
	assign link_pll_freq_reset = link_freq_rst_ff;
	assign video_enable = video_en_ff;
	assign pll_ctrl.hdmi_pll_sm_reset = hdmi_pll_sm_control_ff[`PLL_SM_RESET_BIT];
	assign pll_ctrl.link_pll_sm_reset = link_pll_sm_control_ff[`PLL_SM_RESET_BIT];
	assign pll_ctrl.link_freq_reset_en = freq_ctl_ff[`FREQ_LINK_RESET_BIT];
	assign pll_ctrl.blank_video_block = video_ctl_ff[`VIDEO_NO_BLANK_BIT];

endmodule

// ==== pll_seq_params.svh ====
// Register map, field positions, reset values and timing counts of the sequencer
`ifndef PLL_SEQ_PARAMS_SVH
`define PLL_SEQ_PARAMS_SVH

// Main control map offsets
`define REG_PAGE_SEL 8'h40
`define REG_PAGE_OFS 8'h41
`define REG_PAGE_DATA 8'h42
`define REG_FREQ_CTL 8'h5b
`define REG_BUS_FILTER 8'h16
`define REG_VIDEO_CTL 8'h04

// Pages and paged offsets
`define PAGE_HDMI 8'h10
`define PAGE_LINK 8'h14
`define PAGE_PLL_SM_OFS 8'h49

// Field positions
`define PLL_SM_RESET_BIT 4
`define FREQ_LINK_RESET_BIT 5
`define VIDEO_NO_BLANK_BIT 4

// Reset values
`define PLL_SM_CONTROL_RST 8'h00
`define MAIN_REG_RST 8'h00

// Bus ready time after enable, 2 ms at 10 ns per cycle
`define BUS_READY_MS 2
`define CLK_PERIOD_NS 10
`define BUS_READY_CYCLES ((`BUS_READY_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ==== pll_seq_pkg.sv ====
// Types shared by the sequencer files
package pll_seq_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic hdmi_pll_sm_reset;
		logic link_pll_sm_reset;
		logic link_freq_reset_en;
		logic blank_video_block;
	} pll_ctrl_t;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_WAIT = 2'b01,
		ST_READY = 2'b10
	} boot_state_t;

endpackage

// ==== bus_ready_timer.sv ====
// Counts the settle time after the enable pin rises before the bus opens
`timescale 1ns/1ps
`include "pll_seq_params.svh"

module bus_ready_timer #(
	parameter int READY_CYCLES = `BUS_READY_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic device_enable_pin,
	output logic ready
);

	pll_seq_pkg::boot_state_t state_ff;
	logic [31:0] cnt_ff;

	// Hold off, count, then open; enable low restarts everything
	always_ff @(posedge clk) begin
		if (srst || !device_enable_pin) begin
			state_ff <= pll_seq_pkg::ST_OFF;
			cnt_ff <= 32'h0;
		end else begin
			unique case (state_ff)
				pll_seq_pkg::ST_OFF: begin
					state_ff <= pll_seq_pkg::ST_WAIT;
					cnt_ff <= 32'h0;
				end
				pll_seq_pkg::ST_WAIT: begin
					if (cnt_ff >= 32'(READY_CYCLES - 2)) begin
						state_ff <= pll_seq_pkg::ST_READY;
					end else begin
						cnt_ff <= cnt_ff + 32'h1;
					end
				end
				pll_seq_pkg::ST_READY: begin
					state_ff <= pll_seq_pkg::ST_READY;
				end
				default: begin
					state_ff <= pll_seq_pkg::ST_OFF;
				end
			endcase
		end
	end

	assign ready = (state_ff == pll_seq_pkg::ST_READY);

endmodule

// ==== seq_chk_sva.sv ====
// Port checker for the PLL reset and init sequencer
`timescale 1ns/1ps
`include "pll_seq_params.svh"
module seq_chk #(
	parameter int READY_CYCLES = `BUS_READY_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic device_enable_pin,
	input wire pll_seq_pkg::bus_req_t bus_req,
	input wire logic freq_change_det,
	input wire logic in_blanking,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic bus_ready,
	input wire pll_seq_pkg::pll_ctrl_t pll_ctrl,
	input wire logic link_pll_freq_reset,
	input wire logic video_enable
);
	// Edges since release from reset, saturating
	int cnt_ff;
	always_ff @(posedge clk) begin
		if (srst || !device_enable_pin) begin
			cnt_ff <= 0;
		end else if (cnt_ff < 1000000) begin
			cnt_ff <= cnt_ff + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst || !device_enable_pin);
	early_bus_a: assert property (bus_ready |-> cnt_ff > READY_CYCLES)
		else $error("bus opened early");
	late_bus_a: assert property (cnt_ff > READY_CYCLES + 2 |-> bus_ready)
		else $error("bus never opened");
	rd_ack_a: assert property (bus_req.rd && !bus_req.wr && bus_ready |=> rvalid)
		else $error("read not answered");
	freq_rst_a: assert property (
		link_pll_freq_reset == $past(freq_change_det && pll_ctrl.link_freq_reset_en))
		else $error("frequency reset gating wrong");
	freq_en_wr_a: assert property (
		$changed(pll_ctrl.link_freq_reset_en) |-> $past(bus_req.wr && bus_req.addr == 8'h5b))
		else $error("frequency enable changed without write");
	video_gate_a: assert property ($past(!srst && device_enable_pin) |->
		video_enable == !$past(in_blanking && pll_ctrl.blank_video_block))
		else $error("video gating wrong");
	hdmi_set_a: assert property ($rose(pll_ctrl.hdmi_pll_sm_reset) |->
		$past(bus_req.wr && bus_req.addr == 8'h42 && bus_req.wdata[4]))
		else $error("hdmi reset set without window write");
	link_set_a: assert property ($rose(pll_ctrl.link_pll_sm_reset) |->
		$past(bus_req.wr && bus_req.addr == 8'h42 && bus_req.wdata[4]))
		else $error("link reset set without window write");
endmodule
bind pll_reset_init_sequencer seq_chk #(
	.READY_CYCLES(READY_CYCLES)
) i_seq_chk (
	.clk(clk),
	.srst(srst),
	.device_enable_pin(device_enable_pin),
	.bus_req(bus_req),
	.freq_change_det(freq_change_det),
	.in_blanking(in_blanking),
	.rdata(rdata),
	.rvalid(rvalid),
	.bus_ready(bus_ready),
	.pll_ctrl(pll_ctrl),
	.link_pll_freq_reset(link_pll_freq_reset),
	.video_enable(video_enable)
);

// ==== host_model.sv ====
// Host controller model driving the control bus and the enable pin
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic bus_ready,
	output pll_seq_pkg::bus_req_t bus_req,
	output logic device_enable_pin
);
	initial begin
		bus_req = '0;
		device_enable_pin = 1'h0;
	end
	// One strobed access; idle bus shows inverted last values
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		#1;
		bus_req = {w, !w, a, d};
		@(posedge clk);
		#1;
		q = rvalid ? rdata : 8'hxx;
		bus_req = {2'h0, ~a, ~d};
	endtask
	// Enable only after supplies settle; low pulse is a hard reset
	task automatic set_enable(input logic on);
		@(posedge clk);
		#1;
		device_enable_pin = on;
	endtask
	// No access before the bus opens, bounded wait
	task automatic wait_ready();
		for (int i = 0; i < 50 && bus_ready !== 1'h1; i++) @(posedge clk);
	endtask
	// Init A settings
	task automatic init_a();
		logic [7:0] q;
		access(1'h1, 8'h5b, 8'h00, q);
		access(1'h1, 8'h16, 8'h02, q);
		access(1'h1, 8'h04, 8'h10, q);
	endtask
	// Paged PLL reset pulse, low nibble always zero
	task automatic pll_reset(input logic [7:0] page);
		logic [7:0] q;
		access(1'h1, 8'h40, page, q);
		access(1'h1, 8'h41, 8'h49, q);
		access(1'h1, 8'h42, 8'h10, q);
		access(1'h1, 8'h42, 8'h00, q);
	endtask
endmodule

// ==== pll_reset_init_sequencer_tb_top.sv ====
// Self-checking bench for the PLL reset and init sequencer
`timescale 1ns/1ps
module pll_reset_init_sequencer_tb_top;
	logic clk = 1'h0;
	logic srst;
	logic freq_change_det;
	logic in_blanking;
	logic [7:0] rdata, q;
	logic rvalid, bus_ready, link_pll_freq_reset, video_enable, device_enable_pin;
	pll_seq_pkg::bus_req_t bus_req;
	pll_seq_pkg::pll_ctrl_t pll_ctrl;
	int miscompares = 0;
	int check_count = 0;
	int fr_n = 0;
	int hd_n = 0;
	int lk_n = 0;
	always #5 clk = ~clk;
	pll_reset_init_sequencer #(
		.READY_CYCLES(10)
	) i_pll_reset_init_sequencer (
		.clk(clk),
		.srst(srst),
		.device_enable_pin(device_enable_pin),
		.bus_req(bus_req),
		.freq_change_det(freq_change_det),
		.in_blanking(in_blanking),
		.rdata(rdata),
		.rvalid(rvalid),
		.bus_ready(bus_ready),
		.pll_ctrl(pll_ctrl),
		.link_pll_freq_reset(link_pll_freq_reset),
		.video_enable(video_enable)
	);
	host_model i_host_model (
		.clk(clk),
		.rdata(rdata),
		.rvalid(rvalid),
		.bus_ready(bus_ready),
		.bus_req(bus_req),
		.device_enable_pin(device_enable_pin)
	);
	// Cycles each pulse output is seen high
	always @(posedge clk) begin
		fr_n <= fr_n + int'(link_pll_freq_reset === 1'h1);
		hd_n <= hd_n + int'(pll_ctrl.hdmi_pll_sm_reset === 1'h1);
		lk_n <= lk_n + int'(pll_ctrl.link_pll_sm_reset === 1'h1);
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic pulse();
		@(posedge clk);
		#1 freq_change_det = 1'h1;
		@(posedge clk);
		#1 freq_change_det = 1'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		srst = 1'h1;
		freq_change_det = 1'h0;
		in_blanking = 1'h0;
		repeat (20) @(posedge clk);
		#1 srst = 1'h0;
		i_host_model.set_enable(1'h1);
		i_host_model.access(1'h1, 8'h16, 8'h55, q);
		i_host_model.wait_ready();
		i_host_model.access(1'h0, 8'h16, 8'h00, q);
		chk("early write", 8'h00, q);
		chk("pll_ctrl", 8'h00, {4'h0, pll_ctrl});
		$display("test reset done");
		i_host_model.access(1'h1, 8'h5b, 8'h20, q);
		pulse();
		chk("freq reset on", 8'h01, fr_n[7:0]);
		i_host_model.init_a();
		pulse();
		chk("freq reset off", 8'h01, fr_n[7:0]);
		i_host_model.access(1'h0, 8'h16, 8'h00, q);
		chk("bus filter", 8'h02, q);
		in_blanking = 1'h1;
		repeat (2) @(posedge clk);
		#1 chk("video in blank", 8'h00, {7'h0, video_enable});
		in_blanking = 1'h0;
		repeat (2) @(posedge clk);
		#1 chk("video out of blank", 8'h01, {7'h0, video_enable});
		$display("test init a done");
		i_host_model.access(1'h1, 8'h40, 8'h10, q);
		i_host_model.access(1'h1, 8'h41, 8'h48, q);
		i_host_model.access(1'h1, 8'h42, 8'h10, q);
		chk("wrong offset", 8'h01, {4'h0, pll_ctrl});
		i_host_model.pll_reset(8'h10);
		chk("hdmi pulse", 8'h02, hd_n[7:0]);
		chk("link idle", 8'h00, lk_n[7:0]);
		i_host_model.pll_reset(8'h14);
		chk("link pulse", 8'h02, lk_n[7:0]);
		i_host_model.access(1'h1, 8'h42, 8'h10, q);
		i_host_model.access(1'h0, 8'h42, 8'h00, q);
		chk("window read", 8'h10, q);
		i_host_model.access(1'h1, 8'h42, 8'h00, q);
		i_host_model.access(1'h0, 8'hff, 8'h00, q);
		chk("unmapped", 8'h00, q);
		$display("test init b done");
		i_host_model.set_enable(1'h0);
		repeat (20) @(posedge clk);
		i_host_model.set_enable(1'h1);
		i_host_model.wait_ready();
		i_host_model.access(1'h0, 8'h16, 8'h00, q);
		chk("after hard reset", 8'h00, q);
		chk("ctrl after hard reset", 8'h00, {4'h0, pll_ctrl});
		$display("test hard reset done");
		print_verdict();
	end
	// Watchdog
	initial begin
		#20000;
		miscompares++;
		print_verdict();
	end
endmodule
